// File: rtl/nvm_access_pkg.sv
// Package with register map, field layout and timing constants for the NVM access block
package nvm_access_pkg;
  // Register indices on the plain port (address register and data register in page 0)
  localparam logic [3:0] ADDR_REG = 4'h0;
  localparam logic [3:0] DATA_REG = 4'h1;
  // Control register reached only through pointer page 1, low byte 040h
  localparam logic [7:0] PTR_LOW_REG = 8'h40;
  localparam logic [7:0] PTR_HIGH_VAL = 8'h01;
  // Own registers: pointer bytes, indirect port, status, mask, low-power request
  localparam logic [3:0] PTR_LO_REG = 4'h2;
  localparam logic [3:0] PTR_HI_REG = 4'h3;
  localparam logic [3:0] IND_REG = 4'h4;
  localparam logic [3:0] STAT_REG = 4'h5;
  localparam logic [3:0] MASK_REG = 4'h6;
  localparam logic [3:0] LOWPWR_REG = 4'h7;
  // Control field positions
  localparam int FETCH_GO = 0;
  localparam int FETCH_EN = 1;
  localparam int PROG_GO = 2;
  localparam int PROG_EN = 3;
  // Status bits
  localparam int ST_DONE = 0;
  localparam int ST_FAIL = 1;
  localparam int ADDR_W = 6;
  localparam int DEPTH = 64;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // Write cycle time, in microseconds, and derived cycle count at 100 MHz
  localparam int PROG_TIME_US = 4;
  localparam int CLK_MHZ = 100;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int FETCH_CYCLES = 2;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage

// File: rtl/nvm_access.sv
// Byte-wide data NVM access controller with indirect control register and done interrupt
`timescale 1ns/10ps
// Notes on behaviour
// - Low-power entry during cycle fails it
// - Fetch enable bit 1, fetch start 0
// - Program enable bit 3, start 2
// - Writing zero control clears both enables
// - Fetch end seen when start bit clears
// - Program end seen when start bit clears
// - Start needs enable; hardware clears start
// - Six-bit address, upper bits zero, reset zero
// - Both starts or all four ignored
// - Write end sets done flag, interrupt
module nvm_access
  import nvm_access_pkg::*;
#(
  parameter int PROG_CNT = PROG_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  output logic O_IRQ,
  output logic O_BUSY
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_FETCH = 3'b010,
    S_PROG = 3'b100
  } state_t;

  bus_req_t req;
  assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

  logic [7:0] mem [DEPTH];
  state_t state_q, state_d;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] data_q, ptr_lo_q, ptr_hi_q;
  logic [3:0] ctrl_q, ctrl_d;
  logic [1:0] stat_q, mask_q;
  logic lowpwr_q;
  logic [15:0] cnt_q;
  logic [7:0] rdata_q;
  logic irq_q, busy_q;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  // Indirect port reaches the control register only at the exact pointer value
  wire ctrl_sel = (ptr_hi_q == PTR_HIGH_VAL) && (ptr_lo_q == PTR_LOW_REG);
  wire ind_wr = req.wr && hit(req.addr, IND_REG) && ctrl_sel;
  wire [3:0] wv = req.wdata[3:0];
  // Illegal combinations are dropped whole, leaving the control register untouched
  wire bad_wr = (wv[FETCH_GO] && wv[PROG_GO]) || (wv == 4'hf);
  wire ctrl_wr = ind_wr && !bad_wr;
  wire st_idle = (state_q == S_IDLE);
  wire go_fetch = ctrl_wr && st_idle && wv[FETCH_GO] && ctrl_q[FETCH_EN];
  wire go_prog = ctrl_wr && st_idle && wv[PROG_GO] && ctrl_q[PROG_EN];
  wire cnt_end_fetch = (cnt_q == 16'(FETCH_CYCLES - 1));
  wire cnt_end_prog = (cnt_q == 16'(PROG_CNT - 1));
  // A low-power request while busy aborts the cycle without touching memory
  wire abort = lowpwr_q && !st_idle;
  wire fetch_end = (state_q == S_FETCH) && cnt_end_fetch && !abort;
  wire prog_end = (state_q == S_PROG) && cnt_end_prog && !abort;
  wire stat_wr = req.wr && hit(req.addr, STAT_REG);
  wire [1:0] ev = {abort, prog_end};
  wire [1:0] stat_d = (stat_q & ~(stat_wr ? req.wdata[1:0] : 2'h0)) | ev;

  always_comb begin
    state_d = state_q;
    if (abort) begin
      state_d = S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (go_fetch) state_d = S_FETCH;
          else if (go_prog) state_d = S_PROG;
        end
        S_FETCH: if (cnt_end_fetch) state_d = S_IDLE;
        S_PROG: if (cnt_end_prog) state_d = S_IDLE;
        default: state_d = S_IDLE;
      endcase
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      // Enables follow the write; zero clears both
      ctrl_d[FETCH_EN] = wv[FETCH_EN];
      ctrl_d[PROG_EN] = wv[PROG_EN];
      if (go_fetch) ctrl_d[FETCH_GO] = 1'b1;
      if (go_prog) ctrl_d[PROG_GO] = 1'b1;
    end
    // Start bits are only cleared by hardware, at cycle end or on abort
    if (fetch_end || (abort && state_q == S_FETCH)) ctrl_d[FETCH_GO] = 1'b0;
    if (prog_end || (abort && state_q == S_PROG)) ctrl_d[PROG_GO] = 1'b0;
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      state_q <= S_IDLE;
      addr_q <= '0;
      data_q <= ZERO8;
      ptr_lo_q <= ZERO8;
      ptr_hi_q <= ZERO8;
      ctrl_q <= CTRL_RST;
      stat_q <= IRQ_RST;
      mask_q <= IRQ_RST;
      lowpwr_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      cnt_q <= (st_idle || state_d == S_IDLE) ? '0 : cnt_q + 16'h0001;
      if (req.wr && hit(req.addr, ADDR_REG)) addr_q <= req.wdata[ADDR_W-1:0];
      if (fetch_end) data_q <= mem[addr_q];
      else if (req.wr && hit(req.addr, DATA_REG)) data_q <= req.wdata;
      if (req.wr && hit(req.addr, PTR_LO_REG)) ptr_lo_q <= req.wdata;
      if (req.wr && hit(req.addr, PTR_HI_REG)) ptr_hi_q <= req.wdata;
      if (req.wr && hit(req.addr, MASK_REG)) mask_q <= req.wdata[1:0];
      if (req.wr && hit(req.addr, LOWPWR_REG)) lowpwr_q <= req.wdata[0];
    end
  end

  // Storage array has no reset, as a real NVM array keeps its contents
  always_ff @(posedge I_CLK) begin
    if (prog_end) mem[addr_q] <= data_q;
  end

  logic [7:0] rmux;
  always_comb begin
    rmux = ZERO8;
    unique case (req.addr)
      ADDR_REG: rmux = {2'h0, addr_q};
      DATA_REG: rmux = data_q;
      PTR_LO_REG: rmux = ptr_lo_q;
      PTR_HI_REG: rmux = ptr_hi_q;
      IND_REG: rmux = ctrl_sel ? {4'h0, ctrl_q} : ZERO8;
      STAT_REG: rmux = {6'h00, stat_q};
      MASK_REG: rmux = {6'h00, mask_q};
      LOWPWR_REG: rmux = {7'h00, lowpwr_q};
      default: rmux = ZERO8;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rdata_q <= ZERO8;
      irq_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      rdata_q <= req.rd ? rmux : ZERO8;
      irq_q <= |(stat_d & mask_q);
      busy_q <= (state_d != S_IDLE);
    end
  end

  assign O_RDATA = rdata_q;
  assign O_IRQ = irq_q;
  assign O_BUSY = busy_q;

  // Counts cycles with the program start bit up, so the full write time can be checked
  logic [15:0] held_q;
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      held_q <= '0;
    end else begin
      held_q <= ctrl_q[PROG_GO] ? held_q + 16'h0001 : '0;
    end
  end

  property p_start_needs_enable;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (ind_wr && wv[PROG_GO] && !ctrl_q[PROG_EN]) |=> !ctrl_q[PROG_GO];
  endproperty
  a_start_needs_enable: assert property (p_start_needs_enable)
    else $error("program start took effect without enable");

  property p_both_start_ignored;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (ind_wr && bad_wr && st_idle) |=> (ctrl_q == $past(ctrl_q));
  endproperty
  a_both_start_ignored: assert property (p_both_start_ignored)
    else $error("illegal control write changed the register");

  property p_zero_clears;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (ind_wr && wv == 4'h0) |=> (!ctrl_q[PROG_EN] && !ctrl_q[FETCH_EN]);
  endproperty
  a_zero_clears: assert property (p_zero_clears)
    else $error("zero write left an enable set");

  property p_prog_held;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (state_q == S_PROG && !abort) |-> ctrl_q[PROG_GO];
  endproperty
  a_prog_held: assert property (p_prog_held)
    else $error("program start dropped during the cycle");

  property p_done_flag;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      prog_end |=> (stat_q[ST_DONE] && !ctrl_q[PROG_GO]);
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("write end did not raise done and clear start");

  property p_fetch_end;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      go_fetch |=> ctrl_q[FETCH_GO] ##2 !ctrl_q[FETCH_GO];
  endproperty
  a_fetch_end: assert property (p_fetch_end)
    else $error("fetch start not cleared after the fetch time");

  property p_abort;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      abort |=> (state_q == S_IDLE && stat_q[ST_FAIL]);
  endproperty
  a_abort: assert property (p_abort)
    else $error("low-power entry did not fail the cycle");

  property p_addr_upper;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (req.rd && req.addr == ADDR_REG) |=> (O_RDATA[7:6] == 2'h0);
  endproperty
  a_addr_upper: assert property (p_addr_upper)
    else $error("address upper bits read non-zero");

  property p_blocked;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (req.wr && hit(req.addr, IND_REG) && ptr_hi_q == ZERO8 && st_idle) |=> $stable(ctrl_q);
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("control changed with pointer page zero");

  property p_fetch_needs_enable;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (ind_wr && wv[FETCH_GO] && !ctrl_q[FETCH_EN] && st_idle) |=> !ctrl_q[FETCH_GO];
  endproperty
  a_fetch_needs_enable: assert property (p_fetch_needs_enable)
    else $error("fetch start took effect without enable");

  property p_enables_follow;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      ctrl_wr |=> (ctrl_q[PROG_EN] == $past(wv[PROG_EN])) && (ctrl_q[FETCH_EN] == $past(wv[FETCH_EN]));
  endproperty
  a_enables_follow: assert property (p_enables_follow)
    else $error("enable bits did not follow the control write");

  property p_irq_raise;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      ((stat_q & ~$past(stat_q) & mask_q) != 2'h0) && $stable(mask_q) |-> O_IRQ;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("unmasked status event did not raise the interrupt");

  property p_done_clear;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (stat_wr && req.wdata[ST_DONE] && !prog_end) |=> !stat_q[ST_DONE];
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done flag survived a clear by software");

  property p_prog_length;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      ($fell(ctrl_q[PROG_GO]) && !$past(abort)) |-> (held_q == 16'(PROG_CNT));
  endproperty
  a_prog_length: assert property (p_prog_length)
    else $error("program start not held for the full write time");

  property p_fail_stops;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (abort && state_q == S_PROG) |=> (!ctrl_q[PROG_GO] && !O_BUSY);
  endproperty
  a_fail_stops: assert property (p_fail_stops)
    else $error("aborted write left start or busy set");

  property p_addr_write;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (req.wr && hit(req.addr, ADDR_REG)) |=> (addr_q == $past(req.wdata[ADDR_W-1:0]));
  endproperty
  a_addr_write: assert property (p_addr_write)
    else $error("address register did not take the low six bits");

  property p_guard_read;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (req.rd && hit(req.addr, IND_REG) && !ctrl_sel) |=> (O_RDATA == ZERO8);
  endproperty
  a_guard_read: assert property (p_guard_read)
    else $error("control register visible outside its pointer page");

  c_fetch: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) fetch_end);
  c_prog: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) prog_end);
  c_abort: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) abort);
  c_irq: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) O_IRQ);
  c_refused: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) ind_wr && bad_wr);
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the NVM access controller
`timescale 1ns/10ps
module tb_top;
  import nvm_access_pkg::*;
  // Short write time keeps the run brief
  localparam int PCNT = 8;
  logic clk, rst, wr, rd;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v;
  logic irq, busy;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;

  nvm_access #(.PROG_CNT(PCNT)) i_nvm_access (
    .I_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq), .O_BUSY(busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task test_done;
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Whole sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task rchk(input logic [3:0] a, input logic [7:0] e, input string n);
    rreg(a, v);
    chk(n, e, v);
  endtask

  // Bounded poll of one control bit until the hardware clears it
  task poll(input int b, input string n);
    int k;
    k = 0;
    v = 8'hff;
    while (v[b] !== 1'b0 && k < 40) begin
      rreg(IND_REG, v);
      k++;
    end
    chk(n, 8'h00, {7'h00, v[b]});
  endtask

  task prog(input logic [7:0] d);
    wreg(ADDR_REG, 8'h3f);
    wreg(DATA_REG, d);
    wreg(IND_REG, 8'h08);
    wreg(IND_REG, 8'h0c);
  endtask

  task fetch(input logic [7:0] e, input string n);
    wreg(DATA_REG, 8'h00);
    wreg(IND_REG, 8'h02);
    wreg(IND_REG, 8'h03);
    poll(FETCH_GO, "fetch end");
    rchk(DATA_REG, e, n);
  endtask

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_REG, 8'h00, "addr reset");
    rchk(DATA_REG, 8'h00, "data reset");
    rchk(STAT_REG, 8'h00, "status reset");
    rchk(MASK_REG, 8'h00, "mask reset");
    wreg(ADDR_REG, 8'hff);
    rchk(ADDR_REG, 8'h3f, "addr upper bits");
    wreg(IND_REG, 8'h08);
    wreg(PTR_LO_REG, PTR_LOW_REG);
    wreg(PTR_HI_REG, PTR_HIGH_VAL);
    rchk(IND_REG, 8'h00, "ctrl page guard");
    wreg(IND_REG, 8'h0f);
    rchk(IND_REG, 8'h00, "ctrl all four");
    wreg(IND_REG, 8'h0a);
    wreg(IND_REG, 8'h05);
    rchk(IND_REG, 8'h0a, "ctrl both starts");
    wreg(IND_REG, 8'h00);
    rchk(IND_REG, 8'h00, "ctrl cleared");
    wreg(IND_REG, 8'h04);
    rchk(IND_REG, 8'h00, "prog start no enable");
    wreg(IND_REG, 8'h01);
    rchk(IND_REG, 8'h00, "fetch start no enable");
    wreg(MASK_REG, 8'h01);
    prog(8'ha5);
    @(posedge clk);
    #1 chk("busy", 8'h01, {7'h00, busy});
    rchk(IND_REG, 8'h0c, "prog start held");
    poll(PROG_GO, "prog end");
    chk("irq done", 8'h01, {7'h00, irq});
    rchk(STAT_REG, 8'h01, "done flag");
    wreg(STAT_REG, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("irq cleared", 8'h00, {7'h00, irq});
    fetch(8'ha5, "read back");
    wreg(MASK_REG, 8'h00);
    prog(8'h5a);
    poll(PROG_GO, "prog end masked");
    chk("irq masked", 8'h00, {7'h00, irq});
    rchk(STAT_REG, 8'h01, "done flag masked");
    wreg(STAT_REG, 8'h01);
    wreg(MASK_REG, 8'h02);
    prog(8'h11);
    wreg(LOWPWR_REG, 8'h01);
    poll(PROG_GO, "abort end");
    rchk(STAT_REG, 8'h02, "fail flag");
    chk("irq fail", 8'h01, {7'h00, irq});
    wreg(LOWPWR_REG, 8'h00);
    fetch(8'h5a, "aborted write");
    chk("busy idle", 8'h00, {7'h00, busy});
    wreg(PTR_HI_REG, 8'h00);
    rchk(IND_REG, 8'h00, "ctrl hidden");
    test_done();
  end
endmodule
